// ### logic/cmpcu_pkg.sv
// constants and rule overview for the comparator control unit
// Overview of operation
// - power-off bit set removes comparator power
// - bandgap select picks bandgap reference, else positive pin
// - raw output synchronised into read-only bit, 1-2 cycle latency
// - flag sets on the event chosen by mode field
// - flag clears on vector acknowledge or writing one
// - request only while flag, enable and global enable all set
// - capture routing set sends output to timer capture front end
// - capture routing clear leaves no path to capture logic
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising
// - hysteresis enable on; level picks 20 mV or 50 mV
// - reserved control b bits 5,3,1,0 read zero
// - output enable drives comparator output onto its pin
// - negative input is mux only if mux select and converter off
// - negative pin buffer disable forces its read bit zero
// - positive pin buffer disable forces its read bit zero
// - output high when positive input exceeds negative input
package cmpcu_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CMPCU_OFS_CTRL_A = 8'h00;
    localparam logic [7:0] CMPCU_OFS_CTRL_B = 8'h04;
    localparam logic [7:0] CMPCU_OFS_IBD = 8'h08;
    localparam logic [7:0] CMPCU_OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] CMPCU_OFS_IRQ_MASK = 8'h10;
    // ----------------------------------------
    // control a fields
    // ----------------------------------------
    localparam int CMPCU_A_POWER_OFF = 7;
    localparam int CMPCU_A_BANDGAP = 6;
    localparam int CMPCU_A_SYNCED_OUT = 5;
    localparam int CMPCU_A_FLAG = 4;
    localparam int CMPCU_A_IRQ_EN = 3;
    localparam int CMPCU_A_CAPTURE = 2;
    localparam int CMPCU_A_MODE_HI = 1;
    localparam int CMPCU_A_MODE_LO = 0;
    // ----------------------------------------
    // control b fields
    // ----------------------------------------
    localparam int CMPCU_B_HYST_EN = 7;
    localparam int CMPCU_B_HYST_LEVEL = 6;
    localparam int CMPCU_B_PIN_OE = 4;
    localparam int CMPCU_B_MUX_NEG = 2;
    localparam logic [7:0] CMPCU_B_WRITABLE = 8'hD4;
    // ----------------------------------------
    // input buffer disable fields
    // ----------------------------------------
    localparam int CMPCU_IBD_NEG = 4;
    localparam int CMPCU_IBD_POS = 3;
    // ----------------------------------------
    // interrupt status fields
    // ----------------------------------------
    localparam int CMPCU_ST_EVENT = 0;
    localparam int CMPCU_ST_RISE = 1;
    localparam int CMPCU_ST_FALL = 2;
    localparam logic [2:0] CMPCU_ST_ZERO = 3'h0;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CMPCU_RST_BYTE = 8'h00;
    localparam logic [31:0] CMPCU_RST_WORD = 32'h00000000;
    // ----------------------------------------
    // interrupt modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        CMPCU_MODE_TOGGLE = 2'h0,
        CMPCU_MODE_RSVD = 2'h1,
        CMPCU_MODE_FALL = 2'h2,
        CMPCU_MODE_RISE = 2'h3
    } cmpcu_mode_t;
endpackage

// ### logic/cmpcu_sync_edge.sv
// two-stage synchroniser with edge detection for the comparator output
`timescale 1ns/1ns
`default_nettype none
module cmpcu_sync_edge
    import cmpcu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    output logic synced_o,
    output logic rise_o,
    output logic fall_o
);
    logic stage1;
    logic stage2;
    logic prev;
    // ----------------------------------------
    // synchroniser and history
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            prev <= 1'b0;
        end else begin
            stage1 <= raw_i;
            stage2 <= stage1;
            prev <= stage2;
        end
    end
    assign synced_o = stage2;
    assign rise_o = stage2 & ~prev;
    assign fall_o = ~stage2 & prev;
endmodule
`default_nettype wire

// ### logic/cmpcu_top.sv
// comparator control unit with wishbone register slave
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module cmpcu_top
    import cmpcu_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic CMP_RAW_I,
    input wire logic GLOBAL_IRQ_ENABLE_I,
    input wire logic IRQ_VECTOR_ACK_I,
    input wire logic CONVERTER_ENABLE_I,
    input wire logic POS_PIN_DIN_I,
    input wire logic NEG_PIN_DIN_I,
    output logic CMP_POWER_OFF_O,
    output logic POS_SEL_BANDGAP_O,
    output logic NEG_SEL_MUX_O,
    output logic HYST_ENABLE_O,
    output logic HYST_LEVEL_50MV_O,
    output logic CAPTURE_INPUT_O,
    output logic CMP_PIN_O,
    output logic CMP_PIN_OE_O,
    output logic [7:0] BUFFER_DISABLE_O,
    output logic POS_PIN_READ_O,
    output logic NEG_PIN_READ_O,
    output logic CMP_IRQ_REQ_O,
    output logic INT_O
);
    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic mode_event(input logic [1:0] mode, input logic rise,
            input logic fall);
        logic hit;
        hit = 1'b0;
        case (cmpcu_mode_t'(mode))
            CMPCU_MODE_TOGGLE: hit = rise | fall;
            CMPCU_MODE_FALL: hit = fall;
            CMPCU_MODE_RISE: hit = rise;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wdat,
            input logic [7:0] wmask);
        return (old & ~wmask) | (wdat & wmask);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic power_off;
    logic bandgap_select;
    logic compare_event_flag;
    logic compare_irq_enable;
    logic capture_routing_enable;
    logic [1:0] compare_irq_mode;
    logic hysteresis_enable;
    logic hysteresis_level;
    logic compare_pin_output_enable;
    logic mux_negative_select;
    logic [7:0] input_buffer_disable;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic synced_compare_output;
    logic cmp_rise;
    logic cmp_fall;

    // ----------------------------------------
    // comparator output synchroniser
    // ----------------------------------------
    logic gated_raw;
    assign gated_raw = CMP_RAW_I & ~power_off;

    cmpcu_sync_edge u_sync (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .raw_i(gated_raw),
        .synced_o(synced_compare_output),
        .rise_o(cmp_rise),
        .fall_o(cmp_fall)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire bus_req = CYC_I & STB_I & ~ACK_O;
    wire bus_wr = bus_req & WE_I & SEL_I[0];
    wire hit_a = (ADR_I == CMPCU_OFS_CTRL_A);
    wire hit_b = (ADR_I == CMPCU_OFS_CTRL_B);
    wire hit_ibd = (ADR_I == CMPCU_OFS_IBD);
    wire hit_st = (ADR_I == CMPCU_OFS_IRQ_STATUS);
    wire hit_mask = (ADR_I == CMPCU_OFS_IRQ_MASK);
    wire wr_a = bus_wr & hit_a;
    wire wr_b = bus_wr & hit_b;
    wire wr_ibd = bus_wr & hit_ibd;
    wire wr_st = bus_wr & hit_st;
    wire wr_mask = bus_wr & hit_mask;
    wire [7:0] wbyte = DAT_I[7:0];

    // ----------------------------------------
    // read views
    // ----------------------------------------
    wire [7:0] view_a = {power_off, bandgap_select, synced_compare_output,
        compare_event_flag, compare_irq_enable, capture_routing_enable,
        compare_irq_mode};
    wire [7:0] view_b = {hysteresis_enable, hysteresis_level, 1'b0,
        compare_pin_output_enable, 1'b0, mux_negative_select, 2'h0};
    wire [7:0] view_st = {5'h00, irq_status};
    wire [7:0] view_mask = {5'h00, irq_mask};

    logic [7:0] read_byte;
    always_comb begin
        if (hit_a) begin
            read_byte = view_a;
        end else if (hit_b) begin
            read_byte = view_b;
        end else if (hit_ibd) begin
            read_byte = input_buffer_disable;
        end else if (hit_st) begin
            read_byte = view_st;
        end else if (hit_mask) begin
            read_byte = view_mask;
        end else begin
            read_byte = CMPCU_RST_BYTE;
        end
    end

    // ----------------------------------------
    // event and flag logic
    // ----------------------------------------
    wire cmp_event = mode_event(compare_irq_mode, cmp_rise, cmp_fall);
    wire flag_clear = (wr_a & wbyte[CMPCU_A_FLAG]) | IRQ_VECTOR_ACK_I;
    wire next_flag = cmp_event | (compare_event_flag & ~flag_clear);
    wire [2:0] st_events = {cmp_fall, cmp_rise, cmp_event};
    wire [2:0] st_clear = wr_st ? wbyte[2:0] : CMPCU_ST_ZERO;
    wire [2:0] next_irq_status = st_events | (irq_status & ~st_clear);
    wire [7:0] a_mask = 8'hCF;
    wire [7:0] next_a = merge_byte(view_a, wbyte, a_mask);
    wire [7:0] next_b = merge_byte(view_b, wbyte, CMPCU_B_WRITABLE);

    // ----------------------------------------
    // output decode
    // ----------------------------------------
    wire next_irq_req = next_flag & compare_irq_enable & GLOBAL_IRQ_ENABLE_I;
    wire next_capture = capture_routing_enable & synced_compare_output;
    wire next_neg_mux = mux_negative_select & ~CONVERTER_ENABLE_I;
    wire next_hyst_level = hysteresis_enable & hysteresis_level;
    wire next_pos_read = POS_PIN_DIN_I & ~input_buffer_disable[CMPCU_IBD_POS];
    wire next_neg_read = NEG_PIN_DIN_I & ~input_buffer_disable[CMPCU_IBD_NEG];
    wire next_int = |(next_irq_status & irq_mask);

    // ----------------------------------------
    // control a
    // ----------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            power_off <= 1'b0;
            bandgap_select <= 1'b0;
            compare_irq_enable <= 1'b0;
            capture_routing_enable <= 1'b0;
            compare_irq_mode <= 2'h0;
        end else if (wr_a) begin
            power_off <= next_a[CMPCU_A_POWER_OFF];
            bandgap_select <= next_a[CMPCU_A_BANDGAP];
            compare_irq_enable <= next_a[CMPCU_A_IRQ_EN];
            capture_routing_enable <= next_a[CMPCU_A_CAPTURE];
            compare_irq_mode <= next_a[CMPCU_A_MODE_HI:CMPCU_A_MODE_LO];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            compare_event_flag <= 1'b0;
            irq_status <= CMPCU_ST_ZERO;
        end else begin
            compare_event_flag <= next_flag;
            irq_status <= next_irq_status;
        end
    end

    // ----------------------------------------
    // control b, buffer disable, mask
    // ----------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            hysteresis_enable <= 1'b0;
            hysteresis_level <= 1'b0;
            compare_pin_output_enable <= 1'b0;
            mux_negative_select <= 1'b0;
        end else if (wr_b) begin
            hysteresis_enable <= next_b[CMPCU_B_HYST_EN];
            hysteresis_level <= next_b[CMPCU_B_HYST_LEVEL];
            compare_pin_output_enable <= next_b[CMPCU_B_PIN_OE];
            mux_negative_select <= next_b[CMPCU_B_MUX_NEG];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            input_buffer_disable <= CMPCU_RST_BYTE;
        end else if (wr_ibd) begin
            input_buffer_disable <= wbyte;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            irq_mask <= CMPCU_ST_ZERO;
        end else if (wr_mask) begin
            irq_mask <= wbyte[2:0];
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= CMPCU_RST_WORD;
        end else begin
            ACK_O <= bus_req;
            DAT_O <= {24'h000000, read_byte};
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            CMP_POWER_OFF_O <= 1'b0;
            POS_SEL_BANDGAP_O <= 1'b0;
            NEG_SEL_MUX_O <= 1'b0;
            HYST_ENABLE_O <= 1'b0;
            HYST_LEVEL_50MV_O <= 1'b0;
            CAPTURE_INPUT_O <= 1'b0;
            CMP_PIN_O <= 1'b0;
            CMP_PIN_OE_O <= 1'b0;
            BUFFER_DISABLE_O <= CMPCU_RST_BYTE;
            POS_PIN_READ_O <= 1'b0;
            NEG_PIN_READ_O <= 1'b0;
            CMP_IRQ_REQ_O <= 1'b0;
            INT_O <= 1'b0;
        end else begin
            CMP_POWER_OFF_O <= power_off;
            POS_SEL_BANDGAP_O <= bandgap_select;
            NEG_SEL_MUX_O <= next_neg_mux;
            HYST_ENABLE_O <= hysteresis_enable;
            HYST_LEVEL_50MV_O <= next_hyst_level;
            CAPTURE_INPUT_O <= next_capture;
            CMP_PIN_O <= synced_compare_output & compare_pin_output_enable;
            CMP_PIN_OE_O <= compare_pin_output_enable;
            BUFFER_DISABLE_O <= input_buffer_disable;
            POS_PIN_READ_O <= next_pos_read;
            NEG_PIN_READ_O <= next_neg_read;
            CMP_IRQ_REQ_O <= next_irq_req;
            INT_O <= next_int;
        end
    end
endmodule
`default_nettype wire

// ### testbench/cmpcu_analog_model.sv
// behavioural analog comparator core facing the control unit
`timescale 1ns/1ns
`default_nettype none
module cmpcu_analog_model #(
    parameter logic [11:0] BG_MV = 12'h3E8
) (
    input wire logic power_off_i,
    input wire logic bandgap_i,
    input wire logic mux_i,
    input wire logic [11:0] pos_mv_i,
    input wire logic [11:0] neg_mv_i,
    input wire logic [11:0] mux_mv_i,
    output logic raw_o
);
    wire logic [11:0] pos_mv = bandgap_i ? BG_MV : pos_mv_i;
    wire logic [11:0] neg_mv = mux_i ? mux_mv_i : neg_mv_i;
    // unpowered core reads low
    assign raw_o = !power_off_i && (pos_mv > neg_mv);
endmodule
`default_nettype wire

// ### testbench/cmpcu_chk.sv
// port assertions for the comparator control unit
`timescale 1ns/1ns
`default_nettype none
module cmpcu_chk
    import cmpcu_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic CMP_RAW_I,
    input wire logic GLOBAL_IRQ_ENABLE_I,
    input wire logic CONVERTER_ENABLE_I,
    input wire logic CMP_POWER_OFF_O,
    input wire logic POS_SEL_BANDGAP_O,
    input wire logic NEG_SEL_MUX_O,
    input wire logic HYST_ENABLE_O,
    input wire logic HYST_LEVEL_50MV_O,
    input wire logic CAPTURE_INPUT_O,
    input wire logic CMP_PIN_O,
    input wire logic [7:0] BUFFER_DISABLE_O,
    input wire logic POS_PIN_READ_O,
    input wire logic NEG_PIN_READ_O,
    input wire logic CMP_IRQ_REQ_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    sequence taken;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence ack_pulse;
        ACK_O ##1 !ACK_O;
    endsequence
    sequence ctrl_a_write;
        taken ##0 (WE_I && SEL_I[0] && ADR_I == CMPCU_OFS_CTRL_A);
    endsequence
    chk_ack_one_cycle: assert property (taken |=> ack_pulse)
        else $error("ack not a single pulse");
    chk_read_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_power_write: assert property (ctrl_a_write |-> ##2
        {CMP_POWER_OFF_O, POS_SEL_BANDGAP_O} == $past(DAT_I[7:6], 2))
        else $error("power or bandgap output wrong after write");
    chk_hyst_level: assert property (HYST_LEVEL_50MV_O |-> HYST_ENABLE_O)
        else $error("level without hysteresis");
    chk_capture_path: assert property (CAPTURE_INPUT_O |-> $past(CMP_RAW_I, 3))
        else $error("capture high without comparator");
    chk_pin_path: assert property (CMP_PIN_O |-> $past(CMP_RAW_I, 3))
        else $error("pin high without comparator");
    chk_neg_disable: assert property ((BUFFER_DISABLE_O[4] && $past(BUFFER_DISABLE_O[4]))
        |-> !NEG_PIN_READ_O)
        else $error("negative pin read while disabled");
    chk_pos_disable: assert property ((BUFFER_DISABLE_O[3] && $past(BUFFER_DISABLE_O[3]))
        |-> !POS_PIN_READ_O)
        else $error("positive pin read while disabled");
    chk_irq_gate: assert property (!GLOBAL_IRQ_ENABLE_I |=> !CMP_IRQ_REQ_O)
        else $error("request without global enable");
    chk_neg_mux: assert property (NEG_SEL_MUX_O |-> !$past(CONVERTER_ENABLE_I))
        else $error("mux selected while converter on");
endmodule
bind cmpcu_top cmpcu_chk u_chk (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .CMP_RAW_I(CMP_RAW_I),
    .GLOBAL_IRQ_ENABLE_I(GLOBAL_IRQ_ENABLE_I), .CONVERTER_ENABLE_I(CONVERTER_ENABLE_I),
    .CMP_POWER_OFF_O(CMP_POWER_OFF_O), .POS_SEL_BANDGAP_O(POS_SEL_BANDGAP_O),
    .NEG_SEL_MUX_O(NEG_SEL_MUX_O), .HYST_ENABLE_O(HYST_ENABLE_O),
    .HYST_LEVEL_50MV_O(HYST_LEVEL_50MV_O), .CAPTURE_INPUT_O(CAPTURE_INPUT_O),
    .CMP_PIN_O(CMP_PIN_O), .BUFFER_DISABLE_O(BUFFER_DISABLE_O),
    .POS_PIN_READ_O(POS_PIN_READ_O), .NEG_PIN_READ_O(NEG_PIN_READ_O),
    .CMP_IRQ_REQ_O(CMP_IRQ_REQ_O));
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the comparator control unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, gie = 1'b0;
    logic vack = 1'b0, conv = 1'b0, pdin = 1'b0, ndin = 1'b0;
    logic [7:0] adr = 8'h00, ibd, v;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dato, q;
    logic ack, raw, pwr, bg, nmux, hen, hlev, cap, pin, pinoe, ireq, intr, prd, nrd;
    logic [11:0] pmv = 12'h064, nmv = 12'h1F4, mmv = 12'h1F4;
    int num_errors = 0, cmp_count = 0;
    always #2 clk = ~clk;
    cmpcu_top DUT (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dato), .ACK_O(ack), .CMP_RAW_I(raw),
        .GLOBAL_IRQ_ENABLE_I(gie), .IRQ_VECTOR_ACK_I(vack), .CONVERTER_ENABLE_I(conv),
        .POS_PIN_DIN_I(pdin), .NEG_PIN_DIN_I(ndin), .CMP_POWER_OFF_O(pwr),
        .POS_SEL_BANDGAP_O(bg), .NEG_SEL_MUX_O(nmux), .HYST_ENABLE_O(hen),
        .HYST_LEVEL_50MV_O(hlev), .CAPTURE_INPUT_O(cap), .CMP_PIN_O(pin),
        .CMP_PIN_OE_O(pinoe), .BUFFER_DISABLE_O(ibd), .POS_PIN_READ_O(prd),
        .NEG_PIN_READ_O(nrd), .CMP_IRQ_REQ_O(ireq), .INT_O(intr));
    cmpcu_analog_model M (.power_off_i(pwr), .bandgap_i(bg), .mux_i(nmux), .pos_mv_i(pmv),
        .neg_mv_i(nmv), .mux_mv_i(mmv), .raw_o(raw));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_of_test;
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        chk("ack idle", ack, 1'h0);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        // wait for the answer; only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task wt(input int c);
        repeat (c) @(posedge clk);
    endtask
    function logic ef(input logic [1:0] m, input logic r);
        return m == 2'h0 || (m == 2'h3 && r) || (m == 2'h2 && !r);
    endfunction
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(22968));
        wt(6);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", q, 32'h0);
        end
        bus(1'b1, 8'h04, 32'hFFFFFFFF);
        bus(1'b0, 8'h04, 32'h0);
        chk("ctrl b", q, 32'hD4);
        chk("b outputs", {hen, hlev, pinoe, nmux}, 4'hF);
        conv <= 1'b1;
        wt(2);
        chk("mux with converter", nmux, 1'h0);
        conv <= 1'b0;
        bus(1'b1, 8'h04, 32'h40);
        wt(2);
        chk("hyst off", {hen, hlev, nmux}, 3'h0);
        pmv <= 12'h384;
        bus(1'b1, 8'h00, 32'h80);
        wt(6);
        bus(1'b0, 8'h00, 32'h0);
        chk("power off", {pwr, q[5]}, 2'h2);
        pmv <= 12'h064;
        bus(1'b1, 8'h00, 32'h40);
        wt(6);
        bus(1'b0, 8'h00, 32'h0);
        chk("bandgap", {bg, q[5]}, 2'h3);
        bus(1'b1, 8'h00, 32'h10);
        bus(1'b1, 8'h10, 32'h2);
        for (int m = 0; m < 4; m++) begin
            gie <= 1'($urandom);
            bus(1'b1, 8'h00, 32'(m));
            bus(1'b1, 8'h00, 32'h10 | 32'(m));
            bus(1'b1, 8'h0C, 32'h7);
            bus(1'b1, 8'h00, 32'h08 | 32'(m));
            pmv <= 12'h384;
            wt(6);
            bus(1'b0, 8'h00, 32'h0);
            chk("rise flag", q[5:4], {1'b1, ef(2'(m), 1'b1)});
            chk("irq request", ireq, ef(2'(m), 1'b1) & gie);
            chk("int raised", intr, 1'h1);
            bus(1'b1, 8'h00, 32'h18 | 32'(m));
            bus(1'b1, 8'h0C, 32'h7);
            bus(1'b0, 8'h00, 32'h0);
            chk("flag write one", q[4], 1'h0);
            pmv <= 12'h064;
            wt(6);
            bus(1'b0, 8'h0C, 32'h0);
            chk("status", q, {1'b1, 1'b0, ef(2'(m), 1'b0)});
            chk("int masked", intr, 1'h0);
            vack <= 1'b1;
            wt(1);
            vack <= 1'b0;
            wt(2);
            bus(1'b0, 8'h00, 32'h0);
            chk("vector clear", q[4], 1'h0);
        end
        bus(1'b1, 8'h00, 32'h04);
        pmv <= 12'h384;
        wt(6);
        chk("capture", cap, 1'h1);
        bus(1'b1, 8'h00, 32'h0);
        wt(2);
        chk("no capture", cap, 1'h0);
        bus(1'b1, 8'h04, 32'h10);
        wt(2);
        chk("pin", {pin, pinoe}, 2'h3);
        repeat (8) begin
            v = 8'($urandom);
            pdin <= 1'($urandom);
            ndin <= 1'($urandom);
            bus(1'b1, 8'h08, {24'h0, v});
            wt(2);
            chk("buffer disable", ibd, v);
            chk("pos read", prd, pdin & ~v[3]);
            chk("neg read", nrd, ndin & ~v[4]);
            bus(1'b0, 8'h08, 32'h0);
            chk("ibd readback", q, {24'h0, v});
        end
        end_of_test;
    end
    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
